// ==== hw/spi_serial_consts.vh ====
`ifndef SPI_SERIAL_CONSTS_VH
`define SPI_SERIAL_CONSTS_VH

// ****************************************************************
// Register addresses
// ****************************************************************
`define ADDR_CLOCK_SOURCE 16'hFF14
`define ADDR_PULLDOWN 16'hFF2A
`define ADDR_INPUT_LEVEL 16'hFF2B
`define ADDR_ENABLE_TRIGGER 16'hFF58
`define ADDR_MODE_FORMAT 16'hFF59
`define ADDR_PIN23_SELECT 16'hFF5A
`define ADDR_DATA_LOW 16'hFF5B
`define ADDR_DATA_HIGH 16'hFF5C
`define ADDR_IRQ_MASK 16'hFFEA
`define ADDR_IRQ_FLAG 16'hFFFA

// ****************************************************************
// Field positions
// ****************************************************************
`define BIT_SERIAL_ENABLE 0
`define BIT_TRIGGER 1
`define BIT_OUTPUT_ENABLE 2
`define BIT_MASTER 0
`define BIT_ORDER 1
`define BIT_PHASE 2
`define BIT_POLARITY 3
`define BIT_PIN23_SERIAL 0
`define BIT_READY_SELECT 1
`define BIT_MASK 0
`define BIT_FLAG 0
`define BIT_CLOCK_GP 3

// ****************************************************************
// Reset values
// ****************************************************************
`define RESET_CLOCK_SOURCE 3'h0
`define RESET_PIN_CONTROL 4'hF
`define RESET_NIBBLE 4'h0

// ****************************************************************
// Clock source codes and counts
// ****************************************************************
`define CLKSRC_OFF 3'h0
`define CLKSRC_DIV1 3'h1
`define CLKSRC_DIV2 3'h2
`define CLKSRC_DIV4 3'h3
`define BITS_PER_BYTE 4'h8
`define HALF_DIV1 3'h1
`define HALF_DIV2 3'h2
`define HALF_DIV4 3'h4

`endif

// ==== hw/pin_synchronizer.v ====
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Two-stage synchroniser for asynchronous pin levels
// ****************************************************************
module pin_synchronizer #(
	parameter WIDTH = 4
) (
	input wire ref_clk_in, // System clock
	input wire resetn_in, // Synchronous reset, active low
	input wire [WIDTH-1:0] async_in, // Levels from pins
	output reg [WIDTH-1:0] sync_out // Levels in the clock domain
);

	reg [WIDTH-1:0] meta;

	// Stage one feeds stage two only
	always @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			meta <= {WIDTH{1'b0}};
			sync_out <= {WIDTH{1'b0}};
		end else begin
			meta <= async_in;
			sync_out <= meta;
		end
	end

endmodule

`default_nettype wire

// ==== hw/spi_mode_serial_interface.v ====
`timescale 1ns/1ps
`default_nettype none
`include "spi_serial_consts.vh"

module spi_mode_serial_interface (
	input wire ref_clk_in, // 125 MHz system clock
	input wire resetn_in, // Synchronous reset, active low
	input wire [15:0] reg_addr_in, // Register address
	input wire [3:0] reg_wdata_in, // Register write data
	input wire reg_wr_in, // Write strobe
	input wire reg_rd_in, // Read strobe
	output reg [3:0] reg_rdata_out, // Read data, cycle after strobe
	input wire low_speed_oscillator_clock_in, // Slow clock for master
	input wire sclk_pin_in, // Serial clock pin level
	output reg sclk_out, // Serial clock driven in master mode
	output reg sclk_oe_out, // Serial clock output enable
	input wire serial_data_input_pin_in, // Serial data input pin
	output reg serial_data_output_pin_out, // Serial data output
	output reg serial_data_output_oe_out, // Serial data output enable
	input wire port_pin_twenty_three_in, // Pin 23 level, select low
	output reg slave_ready_output_out, // Ready level on pin 23
	output reg slave_ready_oe_out, // Ready output enable
	output reg [3:0] pulldown_on_out, // Effective pull-downs per pin
	output reg [3:0] schmitt_on_out, // Effective Schmitt levels per pin
	output reg serial_irq_out // Masked completion request
);

	// ****************************************************************
	// Register state
	// ****************************************************************
	reg [2:0] clock_source_select;
	reg clock_source_gp;
	reg [3:0] pin_pulldown;
	reg [3:0] pin_input_level;
	reg serial_function_enable;
	reg clock_trigger_status;
	reg data_output_enable;
	reg master_slave_select;
	reg bit_order_select;
	reg clock_phase_bit;
	reg clock_polarity_bit;
	reg pin23_serial_function_enable;
	reg ready_output_select;
	reg [7:0] shift_data;
	reg serial_irq_mask;
	reg [2:0] mask_gp;
	reg serial_irq_flag;

	// ****************************************************************
	// Engine state
	// ****************************************************************
	localparam ST_IDLE = 2'h0;
	localparam ST_RUN = 2'h1;
	localparam ST_DRAIN = 2'h2;

	reg [1:0] state;
	reg [3:0] bit_count;
	reg [2:0] div_count;
	reg master_clock;
	reg ready_active;
	reg [3:0] sync_prev;
	wire [3:0] sync_level;

	// Bit 0 clock pin, 1 data in, 2 select pin, 3 slow oscillator
	pin_synchronizer #(
		.WIDTH(4)
	) u_sync (
		.ref_clk_in(ref_clk_in),
		.resetn_in(resetn_in),
		.async_in({low_speed_oscillator_clock_in,
			port_pin_twenty_three_in,
			serial_data_input_pin_in,
			sclk_pin_in}),
		.sync_out(sync_level)
	);

	// Divider terminal count for the master clock, zero when stopped
	function [2:0] half_period;
		input [2:0] code;
		begin
			case (code)
			`CLKSRC_DIV1: half_period = `HALF_DIV1;
			`CLKSRC_DIV2: half_period = `HALF_DIV2;
			`CLKSRC_DIV4: half_period = `HALF_DIV4;
			default: half_period = 3'h0;
			endcase
		end
	endfunction

	// ****************************************************************
	// Mode decoding
	// ****************************************************************
	wire is_master, spi_slave, ready_mode, select_low, slow_edge;
	wire master_toggle, pin_rise, pin_fall, clk_rise, clk_fall;
	wire sample_on_rise, sample_edge, out_bit;
	wire [2:0] div_limit;

	assign is_master = serial_function_enable & master_slave_select;
	assign spi_slave = serial_function_enable & ~master_slave_select &
		pin23_serial_function_enable & ~ready_output_select;
	assign ready_mode = serial_function_enable & ~master_slave_select &
		pin23_serial_function_enable & ready_output_select;
	assign select_low = ~sync_level[2];
	assign div_limit = half_period(clock_source_select);
	assign slow_edge = sync_level[3] ^ sync_prev[3];
	assign master_toggle = is_master & (state != ST_IDLE) &
		slow_edge & (div_limit != 3'h0) &
		(div_count == div_limit - 3'h1);
	assign pin_rise = sync_level[0] & ~sync_prev[0];
	assign pin_fall = ~sync_level[0] & sync_prev[0];
	// Slave edges only count while select is low in SPI slave mode
	assign clk_rise = is_master ? (master_toggle & ~master_clock) :
		(pin_rise & (~spi_slave | select_low));
	assign clk_fall = is_master ? (master_toggle & master_clock) :
		(pin_fall & (~spi_slave | select_low));
	// Sample on rise when polarity and phase bits agree
	assign sample_on_rise = clock_polarity_bit == clock_phase_bit;
	assign sample_edge = (state == ST_RUN) &
		(sample_on_rise ? clk_rise : clk_fall);
	assign out_bit = bit_order_select ? shift_data[7] : shift_data[0];

	// ****************************************************************
	// Register writes and the shift engine
	// ****************************************************************
	wire wr_clock, wr_pull, wr_level, wr_ctrl, wr_mode, wr_pin23;
	wire wr_low, wr_high, wr_mask, wr_flag, rd_high, trigger, byte_done;

	assign wr_clock = reg_wr_in & (reg_addr_in == `ADDR_CLOCK_SOURCE);
	assign wr_pull = reg_wr_in & (reg_addr_in == `ADDR_PULLDOWN);
	assign wr_level = reg_wr_in & (reg_addr_in == `ADDR_INPUT_LEVEL);
	assign wr_ctrl = reg_wr_in & (reg_addr_in == `ADDR_ENABLE_TRIGGER);
	assign wr_mode = reg_wr_in & (reg_addr_in == `ADDR_MODE_FORMAT);
	assign wr_pin23 = reg_wr_in & (reg_addr_in == `ADDR_PIN23_SELECT);
	assign wr_low = reg_wr_in & (reg_addr_in == `ADDR_DATA_LOW);
	assign wr_high = reg_wr_in & (reg_addr_in == `ADDR_DATA_HIGH);
	assign wr_mask = reg_wr_in & (reg_addr_in == `ADDR_IRQ_MASK);
	assign wr_flag = reg_wr_in & (reg_addr_in == `ADDR_IRQ_FLAG);
	assign rd_high = reg_rd_in & (reg_addr_in == `ADDR_DATA_HIGH);
	// Trigger needs the serial function already enabled
	assign trigger = wr_ctrl & reg_wdata_in[`BIT_TRIGGER] &
		serial_function_enable & (state == ST_IDLE);
	// Master waits for the clock to return to idle before finishing
	assign byte_done = ((state == ST_RUN) & sample_edge &
		(bit_count == `BITS_PER_BYTE - 4'h1) &
		(~is_master | sample_on_rise == clock_polarity_bit)) |
		((state == ST_DRAIN) & (clk_rise | clk_fall));

	always @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			clock_source_select <= `RESET_CLOCK_SOURCE;
			clock_source_gp <= 1'b0;
			pin_pulldown <= `RESET_PIN_CONTROL;
			pin_input_level <= `RESET_PIN_CONTROL;
			serial_function_enable <= 1'b0;
			data_output_enable <= 1'b0;
			master_slave_select <= 1'b0;
			bit_order_select <= 1'b0;
			clock_phase_bit <= 1'b0;
			clock_polarity_bit <= 1'b0;
			pin23_serial_function_enable <= 1'b0;
			ready_output_select <= 1'b0;
			serial_irq_mask <= 1'b0;
			mask_gp <= 3'h0;
		end else begin
			if (wr_clock) begin
				clock_source_select <= reg_wdata_in[2:0];
				clock_source_gp <= reg_wdata_in[`BIT_CLOCK_GP];
			end
			if (wr_pull) begin
				pin_pulldown <= reg_wdata_in;
			end
			if (wr_level) begin
				pin_input_level <= reg_wdata_in;
			end
			if (wr_ctrl) begin
				serial_function_enable <=
					reg_wdata_in[`BIT_SERIAL_ENABLE];
				data_output_enable <= reg_wdata_in[`BIT_OUTPUT_ENABLE];
			end
			if (wr_mode) begin
				master_slave_select <= reg_wdata_in[`BIT_MASTER];
				bit_order_select <= reg_wdata_in[`BIT_ORDER];
				clock_phase_bit <= reg_wdata_in[`BIT_PHASE];
				clock_polarity_bit <= reg_wdata_in[`BIT_POLARITY];
			end
			if (wr_pin23) begin
				pin23_serial_function_enable <=
					reg_wdata_in[`BIT_PIN23_SERIAL];
				ready_output_select <= reg_wdata_in[`BIT_READY_SELECT];
			end
			if (wr_mask) begin
				serial_irq_mask <= reg_wdata_in[`BIT_MASK];
				mask_gp <= reg_wdata_in[3:1];
			end
		end
	end

	// Byte engine: one shift register, no buffering on either side
	always @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			state <= ST_IDLE;
			bit_count <= 4'h0;
			div_count <= 3'h0;
			master_clock <= 1'b0;
			clock_trigger_status <= 1'b0;
			shift_data <= {`RESET_NIBBLE, `RESET_NIBBLE};
			sync_prev <= 4'h0;
			ready_active <= 1'b0;
			serial_irq_flag <= 1'b0;
		end else begin
			sync_prev <= sync_level;
			if (wr_low) begin
				shift_data[3:0] <= reg_wdata_in;
			end
			if (wr_high) begin
				shift_data[7:4] <= reg_wdata_in;
			end
			if (state == ST_IDLE) begin
				master_clock <= clock_polarity_bit;
			end else if (master_toggle) begin
				master_clock <= ~master_clock;
			end
			if (state == ST_IDLE || master_toggle) begin
				div_count <= 3'h0;
			end else if (is_master && slow_edge) begin
				div_count <= div_count + 3'h1;
			end
			case (state)
			ST_IDLE: begin
				if (trigger) begin
					state <= ST_RUN;
					bit_count <= 4'h0;
					clock_trigger_status <= 1'b1;
					ready_active <= 1'b1;
				end
			end
			ST_RUN: begin
				if (sample_edge) begin
					bit_count <= bit_count + 4'h1;
					if (bit_order_select) begin
						shift_data <= {shift_data[6:0], sync_level[1]};
					end else begin
						shift_data <= {sync_level[1], shift_data[7:1]};
					end
					if (bit_count == `BITS_PER_BYTE - 4'h1 &&
						!byte_done) begin
						state <= ST_DRAIN;
					end
				end
			end
			ST_DRAIN: begin
				if (!is_master) begin
					state <= ST_IDLE;
				end
			end
			default: begin
				state <= ST_IDLE;
			end
			endcase
			if (byte_done) begin
				state <= ST_IDLE;
				clock_trigger_status <= 1'b0;
			end
			// First clock edge or a high-nibble access drops ready
			if (clk_rise || clk_fall || wr_high || rd_high) begin
				ready_active <= 1'b0;
			end
			// A completion in the same cycle as a clear keeps the flag
			if (byte_done) begin
				serial_irq_flag <= 1'b1;
			end else if (wr_flag && reg_wdata_in[`BIT_FLAG]) begin
				serial_irq_flag <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// Read port and pin outputs
	// ****************************************************************
	reg [3:0] next_rdata;

	always @* begin
		next_rdata = 4'h0;
		case (reg_addr_in)
		`ADDR_CLOCK_SOURCE: next_rdata = {clock_source_gp,
			clock_source_select};
		`ADDR_PULLDOWN: next_rdata = pin_pulldown;
		`ADDR_INPUT_LEVEL: next_rdata = pin_input_level;
		`ADDR_ENABLE_TRIGGER: next_rdata = {1'b0, data_output_enable,
			clock_trigger_status, serial_function_enable};
		`ADDR_MODE_FORMAT: next_rdata = {clock_polarity_bit,
			clock_phase_bit, bit_order_select, master_slave_select};
		`ADDR_PIN23_SELECT: next_rdata = {2'h0, ready_output_select,
			pin23_serial_function_enable};
		`ADDR_DATA_LOW: next_rdata = shift_data[3:0];
		`ADDR_DATA_HIGH: next_rdata = shift_data[7:4];
		`ADDR_IRQ_MASK: next_rdata = {mask_gp, serial_irq_mask};
		`ADDR_IRQ_FLAG: next_rdata = {3'h0, serial_irq_flag};
		default: next_rdata = 4'h0;
		endcase
	end

	always @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			reg_rdata_out <= 4'h0;
			sclk_out <= 1'b0;
			sclk_oe_out <= 1'b0;
			serial_data_output_pin_out <= 1'b0;
			serial_data_output_oe_out <= 1'b0;
			slave_ready_output_out <= 1'b0;
			slave_ready_oe_out <= 1'b0;
			pulldown_on_out <= 4'h0;
			schmitt_on_out <= 4'h0;
			serial_irq_out <= 1'b0;
		end else begin
			reg_rdata_out <= reg_rd_in ? next_rdata : 4'h0;
			sclk_out <= master_clock;
			sclk_oe_out <= is_master;
			serial_data_output_pin_out <= out_bit;
			serial_data_output_oe_out <= serial_function_enable &
				data_output_enable;
			// Ready level follows polarity; unusable in SPI slave mode
			slave_ready_output_out <= ready_active ^
				clock_polarity_bit;
			slave_ready_oe_out <= ready_mode;
			// Pull-down and Schmitt act only where a pin is a serial input
			pulldown_on_out <= pin_pulldown & {spi_slave, serial_function_enable,
				1'b0, serial_function_enable & ~master_slave_select};
			schmitt_on_out <= pin_input_level & {spi_slave,
				serial_function_enable, 1'b0,
				serial_function_enable & ~master_slave_select};
			serial_irq_out <= serial_irq_flag & serial_irq_mask;
		end
	end

endmodule

`default_nettype wire

// ==== bench/spi_serial_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module spi_serial_props (
	input wire ref_clk_in, // clock
	input wire resetn_in, // reset, low
	input wire [15:0] reg_addr_in, // address
	input wire [3:0] reg_wdata_in, // write data
	input wire reg_wr_in, // write strobe
	input wire reg_rd_in, // read strobe
	input wire [3:0] reg_rdata_out, // read data
	input wire port_pin_twenty_three_in, // select
	input wire sclk_oe_out, // clock enable
	input wire serial_data_output_oe_out, // data enable
	input wire slave_ready_oe_out, // ready enable
	input wire serial_irq_out // request
);
	reg [3:0] ctl, mode, sel, mask, src, pd, lvl, hi_cnt, exp, msk;
	wire oe_m = ctl[0] & mode[0];
	wire oe_d = ctl[0] & ctl[2];
	wire rdy = sel[1] & sel[0] & ~mode[0];
	wire spi_s = ctl[0] & ~mode[0] & (sel[1:0] == 2'h1);
	wire clr = reg_wr_in && (reg_addr_in == 16'hFFFA || reg_addr_in == 16'hFFEA);
	// ****
	// Shadow of what software wrote
	// ****
	always @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			{ctl, mode, sel, mask, src} <= 20'h0;
			{pd, lvl} <= 8'hFF;
		end else if (reg_wr_in) begin
			case (reg_addr_in)
			16'hFF58: ctl <= reg_wdata_in & 4'h5;
			16'hFF59: mode <= reg_wdata_in;
			16'hFF5A: sel <= reg_wdata_in & 4'h3;
			16'hFFEA: mask <= reg_wdata_in;
			16'hFF14: src <= reg_wdata_in;
			16'hFF2A: pd <= reg_wdata_in;
			16'hFF2B: lvl <= reg_wdata_in;
			default: ;
			endcase
		end
	end
	// Select high for a while means no transfer can have been finishing
	always @(posedge ref_clk_in) begin
		if (!resetn_in || !port_pin_twenty_three_in)
			hi_cnt <= 4'h0;
		else if (hi_cnt != 4'hF)
			hi_cnt <= hi_cnt + 4'h1;
	end
	always @* begin
		exp = 4'h0;
		msk = 4'hF;
		case (reg_addr_in)
		16'hFF14: exp = src;
		16'hFF2A: exp = pd;
		16'hFF2B: exp = lvl;
		16'hFF59: exp = mode;
		16'hFF5A: exp = sel;
		16'hFFEA: exp = mask;
		16'hFF58: begin
			exp = ctl;
			msk = 4'h5;
		end
		16'hFFFA: msk = 4'hE;
		16'hFF5B, 16'hFF5C: msk = 4'h0;
		default: ;
		endcase
	end
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!resetn_in);
	property p_read_regs;
		reg_rd_in |=> ((reg_rdata_out ^ $past(exp)) & $past(msk)) == 4'h0;
	endproperty
	a_read_regs: assert property (p_read_regs)
		else $error("register read mismatch");
	property p_status_hi;
		reg_rd_in && reg_addr_in == 16'hFF58 |=> !reg_rdata_out[3];
	endproperty
	a_status_hi: assert property (p_status_hi)
		else $error("control bit 3 not zero");
	property p_sclk_oe;
		oe_m == $past(oe_m) && oe_m == $past(oe_m, 2) |-> sclk_oe_out == oe_m;
	endproperty
	a_sclk_oe: assert property (p_sclk_oe)
		else $error("clock enable wrong");
	property p_sdo_oe;
		oe_d == $past(oe_d) && oe_d == $past(oe_d, 2)
			|-> serial_data_output_oe_out == oe_d;
	endproperty
	a_sdo_oe: assert property (p_sdo_oe)
		else $error("data enable wrong");
	property p_ready_oe;
		!rdy && !$past(rdy) && !$past(rdy, 2) |-> !slave_ready_oe_out;
	endproperty
	a_ready_oe: assert property (p_ready_oe)
		else $error("ready driven outside ready mode");
	property p_irq_mask;
		!mask[0] && !$past(mask[0]) && !$past(mask[0], 2) |-> !serial_irq_out;
	endproperty
	a_irq_mask: assert property (p_irq_mask)
		else $error("request while masked");
	property p_flag_hold;
		serial_irq_out && !clr && !$past(clr) |=> serial_irq_out;
	endproperty
	a_flag_hold: assert property (p_flag_hold)
		else $error("flag lost without clear");
	property p_select_gate;
		spi_s && hi_cnt > 4'hB && mask[0] && $past(mask[0]) && $past(mask[0], 2)
			|-> !$rose(serial_irq_out);
	endproperty
	a_select_gate: assert property (p_select_gate)
		else $error("transfer done while deselected");
	c_flag: cover property ($rose(serial_irq_out));
	c_master: cover property (sclk_oe_out);
	c_ready: cover property (slave_ready_oe_out);
endmodule
bind spi_mode_serial_interface spi_serial_props chk (
	.ref_clk_in(ref_clk_in),
	.resetn_in(resetn_in),
	.reg_addr_in(reg_addr_in),
	.reg_wdata_in(reg_wdata_in),
	.reg_wr_in(reg_wr_in),
	.reg_rd_in(reg_rd_in),
	.reg_rdata_out(reg_rdata_out),
	.port_pin_twenty_three_in(port_pin_twenty_three_in),
	.sclk_oe_out(sclk_oe_out),
	.serial_data_output_oe_out(serial_data_output_oe_out),
	.slave_ready_oe_out(slave_ready_oe_out),
	.serial_irq_out(serial_irq_out)
);
`default_nettype wire

// ==== bench/spi_far_end.sv ====
`timescale 1ns/1ps
`default_nettype none
module spi_far_end (
	input wire logic ref_clk_in, // clock
	input wire logic sclk_in, // device clock
	input wire logic miso_in, // device data
	output logic sclk_out, // clock to device
	output logic sel_n_out, // select, low
	output logic mosi_out // data to device
);
	localparam int HALF = 8;
	logic [7:0] tx, rx;
	logic slave_on, rise, msb, prev;
	int nbits;
	initial begin
		sclk_out = 1'b0;
		sel_n_out = 1'b1;
		mosi_out = 1'b0;
		slave_on = 1'b0;
		prev = 1'b0;
	end
	// ****
	// Master role; next bit is set half a phase after the sample edge
	// ****
	task automatic master_xfer(input logic [7:0] b, input logic [1:0] fmt,
		input logic first_msb, input logic gate);
		int e;
		int k;
		k = 0;
		rx = 8'h00;
		@(posedge ref_clk_in);
		sclk_out <= fmt[1];
		repeat (HALF) @(posedge ref_clk_in);
		sel_n_out <= gate;
		mosi_out <= first_msb ? b[7] : b[0];
		repeat (HALF) @(posedge ref_clk_in);
		for (e = 0; e < 16; e++) begin
			if (e % 2 == fmt[0])
				rx = first_msb ? {rx[6:0], miso_in} : {miso_in, rx[7:1]};
			sclk_out <= ~sclk_out;
			repeat (HALF / 2) @(posedge ref_clk_in);
			if (e % 2 == fmt[0] && k < 7) begin
				k++;
				mosi_out <= first_msb ? b[7 - k] : b[k];
			end
			repeat (HALF / 2) @(posedge ref_clk_in);
		end
		sel_n_out <= 1'b1;
		mosi_out <= ~mosi_out;
	endtask
	// ****
	// Slave role for master-mode transfers
	// ****
	task automatic slave_load(input logic [7:0] b, input logic samp_rise,
		input logic first_msb);
		tx = b;
		nbits = 0;
		rise = samp_rise;
		msb = first_msb;
		mosi_out <= first_msb ? b[7] : b[0];
		sel_n_out <= 1'b0;
		slave_on = 1'b1;
	endtask
	// Software lifts the general port once the byte is complete
	task automatic slave_done;
		sel_n_out <= 1'b1;
		slave_on = 1'b0;
	endtask
	always @(posedge ref_clk_in) begin
		prev <= sclk_in;
		if (slave_on && !sel_n_out && prev !== sclk_in &&
			sclk_in === rise) begin
			nbits <= nbits + 1;
			if (nbits < 7)
				mosi_out <= msb ? tx[6 - nbits] : tx[nbits + 1];
		end
	end
endmodule
`default_nettype wire

// ==== bench/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk, rstn, wr_s, rd_s, slow;
	logic [15:0] addr;
	logic [3:0] wdata, rdata, pd_on, smt_on, d;
	logic sclk_o, sclk_oe, sdo, sdo_oe, rdy, rdy_oe, irq, p_sclk, p_sel, p_mosi;
	int fails = 0;
	int comparisons = 0;
	int n;
	logic [7:0] pb, db, e;
	logic [7:0] q [$];
	logic [15:0] ra [9] = '{16'hFF14, 16'hFF2A, 16'hFF2B, 16'hFF59, 16'hFFEA,
		16'hFF58, 16'hFF5A, 16'hFFFA, 16'hFF00};
	logic [3:0] rv [9] = '{4'h0, 4'hF, 4'hF, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0};
	spi_mode_serial_interface dut (.ref_clk_in(clk), .resetn_in(rstn),
		.reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr_s),
		.reg_rd_in(rd_s), .reg_rdata_out(rdata),
		.low_speed_oscillator_clock_in(slow), .sclk_pin_in(p_sclk),
		.sclk_out(sclk_o), .sclk_oe_out(sclk_oe),
		.serial_data_input_pin_in(p_mosi), .serial_data_output_pin_out(sdo),
		.serial_data_output_oe_out(sdo_oe), .port_pin_twenty_three_in(p_sel),
		.slave_ready_output_out(rdy), .slave_ready_oe_out(rdy_oe),
		.pulldown_on_out(pd_on), .schmitt_on_out(smt_on), .serial_irq_out(irq));
	spi_far_end partner (.ref_clk_in(clk), .sclk_in(sclk_o), .miso_in(sdo),
		.sclk_out(p_sclk), .sel_n_out(p_sel), .mosi_out(p_mosi));
	task automatic wr(input logic [15:0] a, input logic [3:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_reg(input logic [15:0] a, input logic [3:0] exp);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1;
		check({4'h0, rdata}, {4'h0, exp});
	endtask
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		check(got, exp);
	endtask
	task automatic chk_pin(input logic [3:0] got, input logic [3:0] exp);
		check({4'h0, got}, {4'h0, exp});
	endtask
	task automatic stop_test;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		slow = 1'b0;
		forever #44 slow = ~slow;
	end
	initial begin
		repeat (60000) @(posedge clk);
		fails++;
		stop_test();
	end
	initial begin
		{rstn, wr_s, rd_s, addr, wdata} = 23'h0;
		void'($urandom(31846));
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		for (int i = 0; i < 9; i++)
			chk_reg(ra[i], rv[i]);
		for (int i = 0; i < 5; i++) begin
			d = 4'($urandom);
			wr(ra[i], d);
			chk_reg(ra[i], d);
			wr(ra[i], rv[i]);
		end
		d = 4'($urandom);
		wr(16'hFF58, d & 4'h5);
		chk_reg(16'hFF58, d & 4'h5);
		wr(16'hFF5A, d);
		chk_reg(16'hFF5A, d & 4'h3);
		wr(16'hFF00, 4'hF);
		wr(16'hFFFA, 4'hE);
		wr(16'hFF58, 4'h0);
		wr(16'hFF5A, 4'h0);
		for (int i = 5; i < 9; i++)
			chk_reg(ra[i], rv[i]);
		$display("test registers finished");
		for (int f = 0; f < 8; f++) begin
			pb = 8'($urandom);
			db = 8'($urandom);
			q.push_back(pb);
			wr(16'hFF59, {f[1], f[0], f[2], 1'b0});
			wr(16'hFF5A, 4'h1);
			wr(16'hFFEA, 4'h1);
			wr(16'hFF58, 4'h5);
			wr(16'hFF5B, db[3:0]);
			wr(16'hFF5C, db[7:4]);
			wr(16'hFF58, 4'h7);
			if (f == 0) begin
				chk_pin(pd_on, 4'hD);
				chk_pin(smt_on, 4'hD);
				partner.master_xfer(pb, 2'h0, 1'b0, 1'b1);
				chk_reg(16'hFF58, 4'h7);
			end
			fork
				partner.master_xfer(pb, 2'(f), f[2], 1'b0);
				begin
					repeat (60) @(posedge clk);
					chk_reg(16'hFF58, 4'h7);
					chk_reg(16'hFFFA, 4'h0);
				end
			join
			repeat (4) @(posedge clk);
			e = q.pop_front();
			chk_pin({3'h0, irq}, 4'h1);
			chk_reg(16'hFFFA, 4'h1);
			chk_reg(16'hFF58, 4'h5);
			chk_reg(16'hFF5B, e[3:0]);
			chk_reg(16'hFF5C, e[7:4]);
			chk_byte(partner.rx, db);
			wr(16'hFFFA, 4'h1);
			chk_reg(16'hFFFA, 4'h0);
		end
		wr(16'hFF5A, 4'h3);
		repeat (3) @(posedge clk);
		chk_pin({3'h0, rdy_oe}, 4'h1);
		// Last format left negative polarity, so an idle ready stands high
		chk_pin({3'h0, rdy}, 4'h1);
		wr(16'hFF5A, 4'h1);
		repeat (3) @(posedge clk);
		chk_pin({3'h0, rdy_oe}, 4'h0);
		$display("test slave finished");
		// One byte per running clock code 1 to 3; a byte spans 88 cycles times the divide ratio
		for (int c = 1; c < 4; c++) begin
			pb = 8'($urandom);
			db = 8'($urandom);
			q.push_back(pb);
			wr(16'hFF5A, 4'h0);
			wr(16'hFF59, 4'h1);
			wr(16'hFF14, 4'(c));
			wr(16'hFF58, 4'h5);
			wr(16'hFF5B, db[3:0]);
			wr(16'hFF5C, db[7:4]);
			partner.slave_load(pb, 1'b1, 1'b0);
			wr(16'hFF58, 4'h7);
			for (n = 0; n < 3000 && irq !== 1'b1; n++)
				@(posedge clk);
			partner.slave_done();
			e = q.pop_front();
			chk_pin({3'h0, irq}, 4'h1);
			chk_byte(8'((n + 44) / 88), 8'(1 << (c - 1)));
			chk_pin({3'h0, sclk_oe}, 4'h1);
			chk_pin({3'h0, sclk_o}, 4'h0);
			chk_byte(8'(partner.nbits), 8'h08);
			chk_reg(16'hFF58, 4'h5);
			chk_reg(16'hFF5B, e[3:0]);
			chk_reg(16'hFF5C, e[7:4]);
			wr(16'hFFFA, 4'h1);
		end
		$display("test master finished");
		stop_test();
	end
endmodule
`default_nettype wire
